// [dlm_defines.svh]
// constants for the dc link discharge monitor
// Summary of operation
// - average samples over 1 ms windows
// - one converter step is 520 mV
// - error allowance is 1% plus 2.6 V
// - coding switch selects decay constant
// - each step must remove 20 percent
// - step time from tau and log ratio
// - below 10 V hold switch five tau
// - cooldown lasts ten decay constants
// - indicators encode ready, discharging, cooldown, boot
// - error: power and error on, no discharge
// - start high at boot end means error
// - sustained overvoltage forces error
// - internal supply failure forces error
// - excessive discharge current forces error
// - missed step target forces error
// - rising voltage during discharge forces error
// - error latched until power cycle
// - ready again only with start low
// - current alarm trips at 9.6 A
`ifndef DLM_DEFINES_SVH
`define DLM_DEFINES_SVH
`define DLM_CLK_MHZ      100
`define DLM_SAMPLE_US    100
`define DLM_SAMPLE_CYC   (`DLM_SAMPLE_US * `DLM_CLK_MHZ)
`define DLM_AVG_SAMPLES  4'hA
`define DLM_LSB_MV_X10   6'h34
`define DLM_ERR_DIV      24'h64
`define DLM_ERR_OFS_MV   24'hA28
`define DLM_RESID_MV     24'h2710
`define DLM_OV_MV        24'h200B20
`define DLM_OV_MS        2'h3
`define DLM_I_TRIP_MA    16'h2580
`define DLM_BOOT_MS      20'h0000A
`define DLM_RESID_TAUS   3'h5
`define DLM_COOL_TAUS    4'hA
`define DLM_RATIO_MAX    10'h3FF
`endif

// [dlm_pkg.sv]
// types for the dc link discharge monitor
package dlm_pkg;
   typedef enum logic [2:0] {
      DLM_BOOT  = 3'h0,
      DLM_READY = 3'h1,
      DLM_DISCH = 3'h2,
      DLM_RESID = 3'h3,
      DLM_COOL  = 3'h4,
      DLM_ERROR = 3'h5
   } dlm_state_t;
endpackage : dlm_pkg

// [dlm_monitor.sv]
// discharge switch controller and supervisor
`timescale 1ns/1ps
`include "dlm_defines.svh"
module dlm_monitor #(
   parameter int unsigned SAMPLE_CYC = `DLM_SAMPLE_CYC
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        start_in,
   input  wire logic [3:0]  tau_sel_in,
   input  wire logic        supply_fail_in,
   input  wire logic        adc_valid,
   input  wire logic [11:0] adc_data,
   input  wire logic [15:0] current_ma,
   output logic             adc_req_q,
   output logic             discharge_sw_q,
   output logic             led_power_q,
   output logic             led_error_q,
   output logic             led_discharge_q,
   output logic [23:0]      avg_mv_q,
   output logic             ms_tick_q
);

   // two-stage synchronisers for pins
   logic       start_s1_q;
   logic       start_s2_q;
   logic       fail_s1_q;
   logic       fail_s2_q;
   logic [3:0] sel_s1_q;
   logic [3:0] sel_s2_q;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         start_s1_q <= 1'b0;
         start_s2_q <= 1'b0;
         fail_s1_q  <= 1'b0;
         fail_s2_q  <= 1'b0;
         sel_s1_q   <= 4'h0;
         sel_s2_q   <= 4'h0;
      end
      else
      begin
         start_s1_q <= start_in;
         start_s2_q <= start_s1_q;
         fail_s1_q  <= supply_fail_in;
         fail_s2_q  <= fail_s1_q;
         sel_s1_q   <= tau_sel_in;
         sel_s2_q   <= sel_s1_q;
      end
   end

   // sample pacing and averaging
   logic [31:0] samp_cnt_q;
   logic [31:0] samp_cnt_d;
   logic        adc_req_d;
   logic [15:0] sum_q;
   logic [15:0] sum_d;
   logic [3:0]  nsamp_q;
   logic [3:0]  nsamp_d;
   logic [23:0] avg_mv_d;
   logic        ms_tick_d;
   logic [15:0] sum_full;

   always_comb
   begin
      samp_cnt_d = samp_cnt_q + 32'h1;
      adc_req_d  = 1'b0;
      sum_d      = sum_q;
      nsamp_d    = nsamp_q;
      avg_mv_d   = avg_mv_q;
      ms_tick_d  = 1'b0;
      sum_full   = sum_q + {4'h0, adc_data};
      if (samp_cnt_q >= SAMPLE_CYC - 1)
      begin
         samp_cnt_d = 32'h0;
         adc_req_d  = 1'b1;
      end
      if (adc_valid)
      begin
         sum_d   = sum_full;
         nsamp_d = nsamp_q + 4'h1;
         if (nsamp_q == `DLM_AVG_SAMPLES - 4'h1)
         begin
            sum_d     = 16'h0;
            nsamp_d   = 4'h0;
            avg_mv_d  = 24'(sum_full * `DLM_LSB_MV_X10);
            ms_tick_d = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         samp_cnt_q <= 32'h0;
         adc_req_q  <= 1'b0;
         sum_q      <= 16'h0;
         nsamp_q    <= 4'h0;
         avg_mv_q   <= 24'h0;
         ms_tick_q  <= 1'b0;
      end
      else
      begin
         samp_cnt_q <= samp_cnt_d;
         adc_req_q  <= adc_req_d;
         sum_q      <= sum_d;
         nsamp_q    <= nsamp_d;
         avg_mv_q   <= avg_mv_d;
         ms_tick_q  <= ms_tick_d;
      end
   end

   // measurement error allowance in mV
   function automatic logic [23:0] err_mv(input logic [23:0] v);
      err_mv = v / `DLM_ERR_DIV + `DLM_ERR_OFS_MV;
   endfunction : err_mv

   // decay constant in ms per switch position
   function automatic logic [13:0] tau_ms(input logic [3:0] sel);
      case (sel)
         4'h0:    tau_ms = 14'h0064;
         4'h1:    tau_ms = 14'h00C8;
         4'h2:    tau_ms = 14'h01F4;
         4'h3:    tau_ms = 14'h03E8;
         4'h4:    tau_ms = 14'h07D0;
         4'h5:    tau_ms = 14'h1388;
         default: tau_ms = 14'h2710;
      endcase
   endfunction : tau_ms

   // natural log, Q8, rounded to upper quarter
   function automatic logic [8:0] ln_q8(input logic [3:0] idx);
      case (idx)
         4'h5:    ln_q8 = 9'h068;
         4'h6:    ln_q8 = 9'h08F;
         4'h7:    ln_q8 = 9'h0B1;
         4'h8:    ln_q8 = 9'h0D0;
         4'h9:    ln_q8 = 9'h0EB;
         4'hA:    ln_q8 = 9'h103;
         4'hB:    ln_q8 = 9'h119;
         4'hC:    ln_q8 = 9'h12E;
         4'hD:    ln_q8 = 9'h141;
         4'hE:    ln_q8 = 9'h152;
         4'hF:    ln_q8 = 9'h163;
         default: ln_q8 = 9'h039;
      endcase
   endfunction : ln_q8

   // supervisor state
   dlm_pkg::dlm_state_t st_q;
   dlm_pkg::dlm_state_t st_d;
   logic [19:0] tmr_q;
   logic [19:0] tmr_d;
   logic [13:0] tau_q;
   logic [13:0] tau_d;
   logic [23:0] initial_link_voltage_q;
   logic [23:0] initial_link_voltage_d;
   logic [23:0] step_start_q;
   logic [23:0] step_start_d;
   logic [23:0] prev_mv_q;
   logic [23:0] prev_mv_d;
   logic [1:0]  ov_cnt_q;
   logic [1:0]  ov_cnt_d;
   logic        sw_d;
   logic        led_err_d;
   logic        led_dis_d;

   // step duration from the current step start
   logic [23:0] num_mv;
   logic [23:0] step_target_voltage;
   logic [23:0] measurement_error_allowance;
   logic [23:0] den_mv;
   logic [33:0] ratio_full;
   logic [9:0]  ratio_q8;
   logic [22:0] dt_prod;
   logic [19:0] dt_ms;
   logic [19:0] resid_ms;
   logic [19:0] cool_ms;

   always_comb
   begin
      num_mv = step_start_q + err_mv(step_start_q);
      step_target_voltage = step_start_q - step_start_q / 24'h5;
      measurement_error_allowance = err_mv(step_target_voltage);
      den_mv = 24'h0;
      if (step_target_voltage > measurement_error_allowance)
      begin
         den_mv = step_target_voltage - measurement_error_allowance;
      end
      ratio_full = 34'h0;
      ratio_q8   = `DLM_RATIO_MAX;
      if (den_mv != 24'h0)
      begin
         ratio_full = {2'h0, num_mv, 8'h0} / {10'h0, den_mv};
         if (ratio_full < 34'(`DLM_RATIO_MAX))
         begin
            ratio_q8 = ratio_full[9:0];
         end
      end
      dt_prod = 23'(tau_q * ln_q8(ratio_q8[9:6]));
      dt_ms   = {5'h0, dt_prod[22:8]};
      if (dt_ms == 20'h0)
      begin
         dt_ms = 20'h1;
      end
      resid_ms = 20'(tau_q * `DLM_RESID_TAUS);
      cool_ms  = 20'(tau_q * `DLM_COOL_TAUS);
   end

   always_comb
   begin
      st_d                   = st_q;
      tmr_d                  = tmr_q;
      tau_d                  = tau_q;
      initial_link_voltage_d = initial_link_voltage_q;
      step_start_d           = step_start_q;
      prev_mv_d              = prev_mv_q;
      ov_cnt_d               = ov_cnt_q;
      if (ms_tick_q)
      begin
         if (tmr_q != 20'hFFFFF)
         begin
            tmr_d = tmr_q + 20'h1;
         end
         ov_cnt_d = 2'h0;
         if (avg_mv_q > `DLM_OV_MV && ov_cnt_q != `DLM_OV_MS)
         begin
            ov_cnt_d = ov_cnt_q + 2'h1;
         end
         else if (avg_mv_q > `DLM_OV_MV)
         begin
            ov_cnt_d = ov_cnt_q;
         end
      end
      unique case (st_q)
         dlm_pkg::DLM_BOOT:
         begin
            if (ms_tick_q && tmr_q >= `DLM_BOOT_MS - 20'h1)
            begin
               tau_d = tau_ms(sel_s2_q);
               tmr_d = 20'h0;
               st_d  = start_s2_q ? dlm_pkg::DLM_ERROR : dlm_pkg::DLM_READY;
            end
         end
         dlm_pkg::DLM_READY:
         begin
            if (start_s2_q)
            begin
               initial_link_voltage_d = avg_mv_q;
               step_start_d           = avg_mv_q;
               prev_mv_d              = avg_mv_q;
               tmr_d                  = 20'h0;
               st_d                   = dlm_pkg::DLM_DISCH;
            end
         end
         dlm_pkg::DLM_DISCH:
         begin
            if (current_ma >= `DLM_I_TRIP_MA)
            begin
               st_d = dlm_pkg::DLM_ERROR;
            end
            else if (ms_tick_q)
            begin
               prev_mv_d = avg_mv_q;
               if (avg_mv_q > prev_mv_q + err_mv(prev_mv_q))
               begin
                  st_d = dlm_pkg::DLM_ERROR;
               end
               else if (avg_mv_q < `DLM_RESID_MV)
               begin
                  tmr_d = 20'h0;
                  st_d  = dlm_pkg::DLM_RESID;
               end
               else if (avg_mv_q <= step_target_voltage)
               begin
                  step_start_d = avg_mv_q;
                  tmr_d        = 20'h0;
               end
               else if (tmr_q + 20'h1 >= dt_ms)
               begin
                  st_d = dlm_pkg::DLM_ERROR;
               end
            end
         end
         dlm_pkg::DLM_RESID:
         begin
            if (current_ma >= `DLM_I_TRIP_MA)
            begin
               st_d = dlm_pkg::DLM_ERROR;
            end
            else if (ms_tick_q && tmr_q + 20'h1 >= resid_ms)
            begin
               tmr_d = 20'h0;
               st_d  = dlm_pkg::DLM_COOL;
            end
         end
         dlm_pkg::DLM_COOL:
         begin
            if (tmr_q >= cool_ms && !start_s2_q)
            begin
               st_d = dlm_pkg::DLM_READY;
            end
         end
         dlm_pkg::DLM_ERROR:
         begin
            st_d = dlm_pkg::DLM_ERROR;
         end
         default:
         begin
            st_d = dlm_pkg::DLM_ERROR;
         end
      endcase
      if (fail_s2_q)
      begin
         st_d = dlm_pkg::DLM_ERROR;
      end
      if (ov_cnt_q == `DLM_OV_MS)
      begin
         st_d = dlm_pkg::DLM_ERROR;
      end
      sw_d      = (st_d == dlm_pkg::DLM_DISCH) || (st_d == dlm_pkg::DLM_RESID);
      led_dis_d = (st_d != dlm_pkg::DLM_READY) && (st_d != dlm_pkg::DLM_ERROR);
      led_err_d = (st_d != dlm_pkg::DLM_READY) && !sw_d;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         st_q                   <= dlm_pkg::DLM_BOOT;
         tmr_q                  <= 20'h0;
         tau_q                  <= 14'h0064;
         initial_link_voltage_q <= 24'h0;
         step_start_q           <= 24'h0;
         prev_mv_q              <= 24'h0;
         ov_cnt_q               <= 2'h0;
         discharge_sw_q         <= 1'b0;
         led_power_q            <= 1'b1;
         led_error_q            <= 1'b1;
         led_discharge_q        <= 1'b1;
      end
      else
      begin
         st_q                   <= st_d;
         tmr_q                  <= tmr_d;
         tau_q                  <= tau_d;
         initial_link_voltage_q <= initial_link_voltage_d;
         step_start_q           <= step_start_d;
         prev_mv_q              <= prev_mv_d;
         ov_cnt_q               <= ov_cnt_d;
         discharge_sw_q         <= sw_d;
         led_power_q            <= 1'b1;
         led_error_q            <= led_err_d;
         led_discharge_q        <= led_dis_d;
      end
   end

endmodule : dlm_monitor

// [dlm_link_model.sv]
// converter stand-in feeding link voltage samples
`timescale 1ns/1ps
module dlm_link_model #(
   parameter int GAP = 0
) (
   input  wire logic        sys_clk,
   input  wire logic [11:0] code,
   output logic             adc_valid,
   output logic [11:0]      adc_data
);
   int gap_q = 0;
   initial adc_valid = 1'b0;
   initial adc_data = 12'h000;
   always @(posedge sys_clk)
   begin
      gap_q     <= (gap_q >= GAP) ? 0 : gap_q + 1;
      adc_valid <= (gap_q >= GAP);
      adc_data  <= (gap_q >= GAP) ? code : ~adc_data;
   end
endmodule : dlm_link_model

// [dlm_monitor_properties.sv]
// port assertions for the discharge monitor
`timescale 1ns/1ps
module dlm_monitor_props #(
   parameter int unsigned SAMPLE_CYC = 10000
) (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        start_in,
   input wire logic [3:0]  tau_sel_in,
   input wire logic        supply_fail_in,
   input wire logic        adc_valid,
   input wire logic [11:0] adc_data,
   input wire logic [15:0] current_ma,
   input wire logic        adc_req_q,
   input wire logic        discharge_sw_q,
   input wire logic        led_power_q,
   input wire logic        led_error_q,
   input wire logic        led_discharge_q,
   input wire logic [23:0] avg_mv_q,
   input wire logic        ms_tick_q
);
   wire logic err_st = led_error_q & ~led_discharge_q;
   wire logic rdy_st = ~led_error_q & ~led_discharge_q;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   chk_power_on: assert property (led_power_q)
      else $error("power indicator off");
   chk_switch_leds: assert property (discharge_sw_q == (led_discharge_q & ~led_error_q))
      else $error("switch and indicators disagree");
   chk_error_latch: assert property (err_st |=> err_st)
      else $error("error state left");
   chk_supply_err: assert property (supply_fail_in |-> ##3 err_st)
      else $error("supply failure not handled");
   chk_current_trip: assert property (discharge_sw_q && current_ma >= 16'h2580 |-> ##[1:12] err_st)
      else $error("overcurrent not handled");
   chk_tick_pulse: assert property (ms_tick_q |=> !ms_tick_q)
      else $error("tick longer than one cycle");
   chk_avg_held: assert property (!ms_tick_q |-> $stable(avg_mv_q))
      else $error("average changed without tick");
   chk_req_spacing: assert property (adc_req_q |=> !adc_req_q [*8])
      else $error("sample requests too close");
   chk_start_close: assert property (rdy_st && $rose(start_in) |-> ##3 discharge_sw_q)
      else $error("start did not close switch");
   cover property ($rose(discharge_sw_q));
   cover property ($rose(err_st));
   cover property (ms_tick_q);
endmodule : dlm_monitor_props
bind dlm_monitor dlm_monitor_props #(
   .SAMPLE_CYC(SAMPLE_CYC)
) dlm_monitor_props_inst (
   .sys_clk(sys_clk), .rst_n(rst_n), .start_in(start_in), .tau_sel_in(tau_sel_in),
   .supply_fail_in(supply_fail_in), .adc_valid(adc_valid), .adc_data(adc_data),
   .current_ma(current_ma), .adc_req_q(adc_req_q), .discharge_sw_q(discharge_sw_q),
   .led_power_q(led_power_q), .led_error_q(led_error_q), .led_discharge_q(led_discharge_q),
   .avg_mv_q(avg_mv_q), .ms_tick_q(ms_tick_q)
);

// [tb_dlm_monitor.sv]
// self-checking bench for the discharge monitor
`timescale 1ns/1ps
module tb_dlm_monitor;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        start_in = 1'b0;
   logic [3:0]  tau_sel_in = 4'h0;
   logic        supply_fail_in = 1'b0;
   logic [11:0] code = 12'h7D0;
   logic [15:0] current_ma = 16'h0000;
   logic        adc_valid, adc_req_q, discharge_sw_q, ms_tick_q;
   logic        led_power_q, led_error_q, led_discharge_q;
   logic [11:0] adc_data;
   logic [23:0] avg_mv_q;
   logic [31:0] rng = 32'h2692;
   int          n_fail = 0;
   int          checks_done = 0;
   int          cyc = 0;
   int          n;
   int          n_t0;
   int          n_req = 0;
   int          n_tick = 0;
   int          taus[4] = '{100, 200, 500, 1000};
   always #5 sys_clk = ~sys_clk;
   // count sample requests and averaging ticks
   always @(posedge sys_clk)
   begin
      if (adc_req_q === 1'b1)
         n_req <= n_req + 1;
      if (ms_tick_q === 1'b1)
         n_tick <= n_tick + 1;
   end
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         n_fail = n_fail + 1;
         summarize();
      end
   end
   dlm_link_model #(
      .GAP(0)
   ) dlm_link_model_inst (
      .sys_clk(sys_clk), .code(code), .adc_valid(adc_valid), .adc_data(adc_data)
   );
   dlm_monitor #(
      .SAMPLE_CYC(20)
   ) dlm_monitor_inst (
      .sys_clk(sys_clk), .rst_n(rst_n), .start_in(start_in), .tau_sel_in(tau_sel_in),
      .supply_fail_in(supply_fail_in), .adc_valid(adc_valid), .adc_data(adc_data),
      .current_ma(current_ma), .adc_req_q(adc_req_q), .discharge_sw_q(discharge_sw_q),
      .led_power_q(led_power_q), .led_error_q(led_error_q), .led_discharge_q(led_discharge_q),
      .avg_mv_q(avg_mv_q), .ms_tick_q(ms_tick_q)
   );
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs
   function automatic logic [23:0] exp_avg(input logic [11:0] c);
      return 24'(c) * 24'h208;
   endfunction : exp_avg
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic tk(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask : tk
   // power, error, discharge indicators
   task automatic leds(input logic [2:0] e);
      chk({21'h0, led_power_q, led_error_q, led_discharge_q}, {21'h0, e});
   endtask : leds
   task automatic boot(input logic s);
      rst_n = 1'b0;
      start_in = s;
      code = 12'h7D0;
      current_ma = 16'h0000;
      tk(16);
      rst_n = 1'b1;
      tk(2);
      leds(3'h7);
      tk(200);
      leds(s ? 3'h6 : 3'h4);
   endtask : boot
   task automatic go();
      start_in = 1'b1;
      tk(3);
      chk(24'(discharge_sw_q), 24'h1);
      leds(3'h5);
   endtask : go
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   initial
   begin
      boot(1'b1);
      start_in = 1'b0;
      tk(300);
      leds(3'h6);
      boot(1'b0);
      n = n_req;
      n_t0 = n_tick;
      tk(200);
      chk(24'(n_req - n), 24'hA);
      chk(24'(n_tick - n_t0), 24'h14);
      repeat (6)
      begin
         rng = xs(rng);
         code = 12'(rng[10:0]);
         current_ma = 16'(rng[12:0]);
         tk(27);
         chk(avg_mv_q, exp_avg(code));
      end
      code = 12'hFFF;
      tk(25);
      leds(3'h4);
      tk(25);
      leds(3'h6);
      chk(avg_mv_q, exp_avg(12'hFFF));
      boot(1'b0);
      supply_fail_in = 1'b1;
      tk(3);
      leds(3'h6);
      supply_fail_in = 1'b0;
      start_in = 1'b1;
      tk(20);
      leds(3'h6);
      boot(1'b0);
      go();
      current_ma = 16'h2580;
      tk(15);
      leds(3'h6);
      boot(1'b0);
      go();
      code = 12'h834;
      tk(40);
      leds(3'h6);
      foreach (taus[i])
      begin
         tau_sel_in = 4'(i);
         boot(1'b0);
         go();
         tk(taus[i] * 36 / 10);
         leds(3'h5);
         tk(taus[i] * 9 / 10);
         leds(3'h6);
      end
      tau_sel_in = 4'h0;
      boot(1'b0);
      tau_sel_in = 4'h9;
      go();
      current_ma = 16'h257F;
      while (code > 12'h15)
      begin
         code = code - code / 4;
         tk(30);
      end
      leds(3'h5);
      code = 12'h00A;
      n = 0;
      while (discharge_sw_q === 1'b1 && n < 6000)
      begin
         tk(1);
         n++;
      end
      chk(24'(n >= 4990 && n <= 5020), 24'h1);
      leds(3'h7);
      start_in = 1'b0;
      tk(9980);
      leds(3'h7);
      start_in = 1'b1;
      tk(100);
      leds(3'h7);
      start_in = 1'b0;
      tk(4);
      leds(3'h4);
      go();
      summarize();
   end
endmodule : tb_dlm_monitor
